// File: rtl/pir_rerouter.v
// pci interrupt to isa irq rerouter, two write-only routing bytes
`timescale 1ns/10ps
`default_nettype none
`include "pir_defs.vh"

module pir_rerouter #(
    parameter LINES = 4
) (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire io_cs_b_i,
    input wire io_wr_b_i,
    input wire [`PIR_ADDR_W-1:0] io_addr_i,
    input wire [7:0] io_data_i,
    input wire pci_irq_line_a_n_i,
    input wire pci_irq_line_b_n_i,
    input wire pci_irq_line_c_n_i,
    input wire pci_irq_line_d_n_i,
    output reg [LINES-1:0] apic_irq_n_o,
    output reg [`PIR_NUM_IRQ-1:0] isa_irq_o,
    output reg [7:0] route_ab_o,
    output reg [7:0] route_cd_o
);

    reg [7:0] route_ctrl_lines_a_b_ff;
    reg [7:0] route_ctrl_lines_c_d_ff;
    reg io_wr_b_ff;
    reg [7:0] nxt_ab;
    reg [7:0] nxt_cd;
    reg [LINES-1:0] nxt_apic_n;
    reg [`PIR_NUM_IRQ-1:0] nxt_isa;
    wire wr_edge;
    wire hit_ab;
    wire hit_cd;
    wire [3:0] code_a;
    wire [3:0] code_b;
    wire [3:0] code_c;
    wire [3:0] code_d;
    wire apic_a_n;
    wire apic_b_n;
    wire apic_c_n;
    wire apic_d_n;
    wire [`PIR_NUM_IRQ-1:0] isa_a;
    wire [`PIR_NUM_IRQ-1:0] isa_b;
    wire [`PIR_NUM_IRQ-1:0] isa_c;
    wire [`PIR_NUM_IRQ-1:0] isa_d;

    // write taken once, on the falling edge of the strobe
    assign wr_edge = io_wr_b_ff & ~io_wr_b_i & ~io_cs_b_i;
    assign hit_ab = wr_edge & (io_addr_i == `PIR_OFS_AB);
    assign hit_cd = wr_edge & (io_addr_i == `PIR_OFS_CD);

    // a0 picks the byte, each nibble is one line
    always @* begin
        nxt_ab = route_ctrl_lines_a_b_ff;
        nxt_cd = route_ctrl_lines_c_d_ff;
        if (hit_ab) begin
            nxt_ab[`PIR_LO_NIB] = io_data_i[`PIR_LO_NIB];
            nxt_ab[`PIR_HI_NIB] = io_data_i[`PIR_HI_NIB];
        end else if (hit_cd) begin
            nxt_cd[`PIR_LO_NIB] = io_data_i[`PIR_LO_NIB];
            nxt_cd[`PIR_HI_NIB] = io_data_i[`PIR_HI_NIB];
        end
    end

    assign code_a = route_ctrl_lines_a_b_ff[`PIR_LO_NIB];
    assign code_b = route_ctrl_lines_a_b_ff[`PIR_HI_NIB];
    assign code_c = route_ctrl_lines_c_d_ff[`PIR_LO_NIB];
    assign code_d = route_ctrl_lines_c_d_ff[`PIR_HI_NIB];

    // one decoder per interrupt line
    pir_line_route #(
        .NUM_IRQ(`PIR_NUM_IRQ)
    ) u_route_a (
        .code_i(code_a),
        .line_n_i(pci_irq_line_a_n_i),
        .apic_n_o(apic_a_n),
        .isa_o(isa_a)
    );

    pir_line_route #(
        .NUM_IRQ(`PIR_NUM_IRQ)
    ) u_route_b (
        .code_i(code_b),
        .line_n_i(pci_irq_line_b_n_i),
        .apic_n_o(apic_b_n),
        .isa_o(isa_b)
    );

    pir_line_route #(
        .NUM_IRQ(`PIR_NUM_IRQ)
    ) u_route_c (
        .code_i(code_c),
        .line_n_i(pci_irq_line_c_n_i),
        .apic_n_o(apic_c_n),
        .isa_o(isa_c)
    );

    pir_line_route #(
        .NUM_IRQ(`PIR_NUM_IRQ)
    ) u_route_d (
        .code_i(code_d),
        .line_n_i(pci_irq_line_d_n_i),
        .apic_n_o(apic_d_n),
        .isa_o(isa_d)
    );

    // steered lines share an irq by or
    always @* begin
        nxt_apic_n = {LINES{1'b1}};
        nxt_apic_n[0] = apic_a_n;
        nxt_apic_n[1] = apic_b_n;
        nxt_apic_n[2] = apic_c_n;
        nxt_apic_n[3] = apic_d_n;
        nxt_isa = isa_a | isa_b | isa_c | isa_d;
    end

    // strobe history for the falling edge detect
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            io_wr_b_ff <= 1'b1;
        end else begin
            io_wr_b_ff <= io_wr_b_i;
        end
    end

    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            route_ctrl_lines_a_b_ff <= `PIR_ROUTE_RST;
            route_ctrl_lines_c_d_ff <= `PIR_ROUTE_RST;
        end else begin
            route_ctrl_lines_a_b_ff <= nxt_ab;
            route_ctrl_lines_c_d_ff <= nxt_cd;
        end
    end

    // every output straight from a flip-flop
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            apic_irq_n_o <= {LINES{1'b1}};
            isa_irq_o <= {`PIR_NUM_IRQ{1'b0}};
            route_ab_o <= `PIR_ROUTE_RST;
            route_cd_o <= `PIR_ROUTE_RST;
        end else begin
            apic_irq_n_o <= nxt_apic_n;
            isa_irq_o <= nxt_isa;
            route_ab_o <= route_ctrl_lines_a_b_ff;
            route_cd_o <= route_ctrl_lines_c_d_ff;
        end
    end

endmodule // pir_rerouter

// routing decode for one interrupt line
module pir_line_route #(
    parameter NUM_IRQ = `PIR_NUM_IRQ
) (
    input wire [3:0] code_i,
    input wire line_n_i,
    output reg apic_n_o,
    output reg [NUM_IRQ-1:0] isa_o
);

    reg [NUM_IRQ-1:0] sel;
    wire line_active;

    assign line_active = ~line_n_i;

    // one-hot irq select from the nibble code
    always @* begin
        sel = {NUM_IRQ{1'b0}};
        case (code_i)
            `PIR_CODE_PASS: begin
                sel = {NUM_IRQ{1'b0}};
            end
            `PIR_CODE_IRQ3: begin
                sel[`PIR_IRQ3_BIT] = 1'b1;
            end
            `PIR_CODE_IRQ5: begin
                sel[`PIR_IRQ5_BIT] = 1'b1;
            end
            `PIR_CODE_IRQ7: begin
                sel[`PIR_IRQ7_BIT] = 1'b1;
            end
            `PIR_CODE_IRQ9: begin
                sel[`PIR_IRQ9_BIT] = 1'b1;
            end
            `PIR_CODE_IRQ10: begin
                sel[`PIR_IRQ10_BIT] = 1'b1;
            end
            `PIR_CODE_IRQ11: begin
                sel[`PIR_IRQ11_BIT] = 1'b1;
            end
            `PIR_CODE_IRQ15: begin
                sel[`PIR_IRQ15_BIT] = 1'b1;
            end
            default: begin
                sel = {NUM_IRQ{1'b0}};
            end
        endcase
    end

    // a line goes to the apic or to one irq, never both
    always @* begin
        apic_n_o = 1'b1;
        isa_o = {NUM_IRQ{1'b0}};
        if (sel == {NUM_IRQ{1'b0}}) begin
            apic_n_o = line_n_i;
        end else begin
            isa_o = sel & {NUM_IRQ{line_active}};
        end
    end

endmodule // pir_line_route
`default_nettype wire

// File: shared/pir_defs.vh
// register offsets, field positions, routing codes and reset values for the interrupt rerouter
`ifndef PIR_DEFS_VH
`define PIR_DEFS_VH
`define PIR_ADDR_W 12
`define PIR_OFS_AB 12'hCA4
`define PIR_OFS_CD 12'hCA5
`define PIR_ROUTE_RST 8'h00
`define PIR_LO_NIB 3:0
`define PIR_HI_NIB 7:4
`define PIR_CODE_PASS 4'h0
`define PIR_CODE_IRQ3 4'h3
`define PIR_CODE_IRQ5 4'h5
`define PIR_CODE_IRQ7 4'h7
`define PIR_CODE_IRQ9 4'h9
`define PIR_CODE_IRQ10 4'hA
`define PIR_CODE_IRQ11 4'hB
`define PIR_CODE_IRQ15 4'hF
`define PIR_NUM_IRQ 7
`define PIR_IRQ3_BIT 0
`define PIR_IRQ5_BIT 1
`define PIR_IRQ7_BIT 2
`define PIR_IRQ9_BIT 3
`define PIR_IRQ10_BIT 4
`define PIR_IRQ11_BIT 5
`define PIR_IRQ15_BIT 6
`endif

// File: testbench/pir_rerouter_sva.sv
// port checks for the interrupt rerouter
`timescale 1ns/10ps
`default_nettype none
module pir_sva #(parameter LINES = 4) (input wire logic sys_clk_i, rst_b_i, io_cs_b_i, io_wr_b_i,
    input wire logic [11:0] io_addr_i, input wire logic [7:0] io_data_i, route_ab_o,
    input wire logic [LINES-1:0] apic_irq_n_o, input wire logic [6:0] isa_irq_o, input wire logic pci_irq_line_a_n_i);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_fall; !io_wr_b_i && $past(io_wr_b_i); endsequence
    sequence s_a(c); route_ab_o[3:0] == c && $past(route_ab_o[3:0]) == c; endsequence
    a_write_ab: assert property (s_fall ##0 !io_cs_b_i && io_addr_i == 12'hCA4
        |-> ##2 route_ab_o == $past(io_data_i, 2)) else $error("ab write lost");
    a_foreign_addr: assert property (s_fall ##0 io_addr_i[11:1] != 11'h652 |-> ##1 $stable(route_ab_o) [*3])
        else $error("foreign write taken");
    a_cs_high: assert property (s_fall ##0 io_cs_b_i |-> ##1 $stable(route_ab_o) [*3]) else $error("cs high taken");
    a_reset_pass: assert property (disable iff (1'b0) !rst_b_i |=> &apic_irq_n_o && !{isa_irq_o, route_ab_o})
        else $error("bad reset state");
    a_steer_apic: assert property (s_a(4'h3) |-> apic_irq_n_o[0]) else $error("steered line at apic");
    a_pass_apic: assert property (s_a(4'h0) ##0 $past(rst_b_i)
        |-> apic_irq_n_o[0] == $past(pci_irq_line_a_n_i)) else $error("passed line lost");
endmodule // pir_sva
bind pir_rerouter pir_sva #(.LINES(LINES)) u_sva(.*);
`default_nettype wire

// File: testbench/pir_host.sv
// host model issuing isa i/o byte writes
`timescale 1ns/10ps
`default_nettype none
module pir_host(input wire logic sys_clk_i, output logic cs_b_o, wr_b_o, output logic [11:0] addr_o,
    output logic [7:0] data_o);
    initial {cs_b_o, wr_b_o, addr_o, data_o} = 22'h3FFFFF;
    task automatic wr(input logic [19:0] v, input logic c);
        @(posedge sys_clk_i) {cs_b_o, wr_b_o, addr_o, data_o} <= {c, 1'b0, v};
        @(posedge sys_clk_i) {cs_b_o, wr_b_o, addr_o, data_o} <= {2'b11, ~v};
        repeat (3) @(negedge sys_clk_i);
    endtask
endmodule // pir_host
`default_nettype wire

// File: testbench/tb_pir_rerouter.sv
// testbench for the interrupt rerouter
`timescale 1ns/10ps
`default_nettype none
module tb_pir_rerouter;
    logic sys_clk_i = 1'b0, rst_b_i = 1'b0, io_cs_b_i, io_wr_b_i;
    logic [11:0] io_addr_i;
    logic [7:0] io_data_i, route_ab_o, route_cd_o;
    logic [3:0] pci_n = 4'hA, apic_irq_n_o;
    logic [6:0] isa_irq_o;
    logic [3:0] code [7] = '{4'h3, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hF};
    int err_count = 0, n_tests = 0;
    wire [27:0] obs = {route_ab_o, route_cd_o, apic_irq_n_o, 1'b0, isa_irq_o};
    pir_rerouter dut(.*, .pci_irq_line_a_n_i(pci_n[0]), .pci_irq_line_b_n_i(pci_n[1]),
        .pci_irq_line_c_n_i(pci_n[2]), .pci_irq_line_d_n_i(pci_n[3]));
    pir_host host(.sys_clk_i, .cs_b_o(io_cs_b_i), .wr_b_o(io_wr_b_i), .addr_o(io_addr_i), .data_o(io_data_i));
    initial forever #20 sys_clk_i = ~sys_clk_i;
    task automatic chk(input logic [27:0] s, e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %0t %h %h", $time, s, e);
        end
    endtask
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(negedge sys_clk_i);
        chk(obs, 28'h0000A00);
        @(posedge sys_clk_i) pci_n <= 4'h0;
        foreach (code[i]) begin
            host.wr({12'hCA4, 4'h0, code[i]}, 1'b0);
            chk(obs, {4'h0, code[i], 12'h001, 8'h01 << i});
        end
        host.wr(20'hCA4A0, 1'b0);
        chk(obs, 28'hA000210);
        host.wr(20'hCA51C, 1'b0);
        chk(obs, 28'hA01C210);
        host.wr(20'hCA633, 1'b0);
        host.wr(20'hCA433, 1'b1);
        chk(obs, 28'hA01C210);
        host.wr(20'hCA5B0, 1'b0);
        chk(obs, 28'hA0B0A30);
        @(posedge sys_clk_i) pci_n <= 4'hA;
        repeat (3) @(negedge sys_clk_i);
        chk(obs, 28'hA0B0A00);
        @(posedge sys_clk_i) rst_b_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(negedge sys_clk_i);
        chk(obs, 28'h0000A00);
        tally_and_finish;
    end
endmodule // tb_pir_rerouter
`default_nettype wire
